// ===== hdl/ras_pkg.sv
package ras_pkg;

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int unsigned PC_W      = 21;
  localparam int unsigned PTR_W     = 5;
  localparam int unsigned DEPTH     = 31;
  localparam logic [PTR_W-1:0] PTR_EMPTY = 5'h00;
  localparam logic [PTR_W-1:0] PTR_TOP   = 5'h1f;
  localparam logic [PC_W-1:0]  PC_STEP   = 21'h00_0002;

  // ------------------------------------------------------------
  // Register map (APB byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_PTR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_TOP_LOW    = 8'h04;
  localparam logic [7:0] ADDR_TOP_HIGH   = 8'h08;
  localparam logic [7:0] ADDR_TOP_UPPER  = 8'h0c;
  localparam logic [7:0] ADDR_CONFIG     = 8'h10;

  // Register fields: pointer/status bits, top-upper width, config reset value
  localparam int unsigned FULL_BIT  = 7;
  localparam int unsigned UNF_BIT   = 6;
  localparam int unsigned UPPER_W   = 5;
  localparam logic        CFG_RESET = 1'b1;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    RAS_NONE, RAS_CALL, RAS_RELATIVE_CALL_OP, RAS_INT_ACK, RAS_RETURN, RAS_LIT_RETURN,
    RAS_INT_RETURN, RAS_SW_PUSH, RAS_SW_POP
  } ras_op_type;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] working_register;
    logic [3:0] bank_select_register;
  } ras_ctx_type;

  typedef struct packed {
    ras_op_type      op;
    logic            fast;
    logic [PC_W-1:0] pc;
  } ras_req_type;

endpackage

// ===== hdl/ras_entry_mem.sv
`timescale 1ns/1ns
module ras_entry_mem #(
  parameter int unsigned DEPTH_P = 31,
  parameter int unsigned WIDTH_P = 21,
  parameter int unsigned AW_P    = 5
) (
  // Clock
  input  wire logic               clk,
  // Write port
  input  wire logic               we,
  input  wire logic [AW_P-1:0]    waddr,
  input  wire logic [WIDTH_P-1:0] wdata,
  // Read port
  input  wire logic [AW_P-1:0]    raddr,
  output logic      [WIDTH_P-1:0] rdata
);
  // Entry k lives at pointer k+1; pointer zero has no storage
  logic [WIDTH_P-1:0] mem [DEPTH_P];

  always_ff @(posedge clk) begin
    if (we && waddr != '0) begin
      mem[waddr - AW_P'(1)] <= wdata;
    end
  end

  always_comb begin
    rdata = '0;
    if (raddr != '0) begin
      rdata = mem[raddr - AW_P'(1)];
    end
  end
endmodule

// ===== hdl/ras_shadow.sv
`timescale 1ns/1ns
module ras_shadow
  import ras_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Control
  input  wire logic        save,
  input  wire ras_pkg::ras_ctx_type live,
  // Saved copy
  output ras_pkg::ras_ctx_type saved
);
  ras_ctx_type saved_r;
  ras_ctx_type saved_nxt;

  // Single level: a later save simply overwrites the earlier one
  always_comb begin
    saved_nxt = saved_r;
    if (save) begin
      saved_nxt = live;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      saved_r <= '0;
    end else begin
      saved_r <= saved_nxt;
    end
  end

  assign saved = saved_r;
endmodule

// ===== hdl/ras_ctrl.sv
`timescale 1ns/1ns
// How it works
// - Five-bit pointer holds a value from zero to thirty-one.
// - Push increments then writes; pop reads then decrements.
// - Any reset returns the pointer to zero.
// - Software may read and write the pointer value.
// - Full flag sets after thirty-one pushes without a pop.
// - Error reset on: 31st push stores pc plus two, flags, resets, pointer zero.
// - Error reset off: pointer stays at 31, later pushes are dropped.
// - Pop at zero returns zero, sets underflow, pointer stays zero.
// - Flags clear only by software or power-on reset.
// - Error reset on: flag then device reset; off: flag only.
// - Underflow without reset option is not a reset.
// - Status byte: full bit 7, underflow bit 6, bit 5 zero, pointer 4..0.
// - Software push stores current pc in a new top entry.
// - Software pop only decrements the pointer; at zero it sets underflow instead.
// - Three top-entry byte registers are writable.
// - One-deep shadow of status, working, bank; not software visible.
// - Every interrupt vector loads the shadow copies.
// - Fast interrupt return restores from the shadow copies.
// - Fast call saves, fast return restores the shadow copies.
// - A nested interrupt overwrites the shadow; only one level.
// - Storage is thirty-one entries of twenty-one bits, private.
// - Calls and interrupt acknowledge push; returns pop.
// - Pointer zero has no entry behind it.
module ras_ctrl
  import ras_pkg::*;
#(
  parameter int unsigned DEPTH_P = DEPTH,
  parameter int unsigned PC_W_P  = PC_W
) (
  // Clock and resets
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 por,
  // Sequencer request
  input  wire ras_pkg::ras_req_type req,
  input  wire ras_pkg::ras_ctx_type live_ctx,
  // Sequencer answer
  output logic [PC_W_P-1:0]         pop_pc,
  output logic                      pop_valid,
  output ras_pkg::ras_ctx_type      restore_ctx,
  output logic                      restore_valid,
  output logic                      stack_error_reset,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [PTR_W-1:0]  ptr_r, ptr_nxt;
  logic              full_r, full_nxt;
  logic              unf_r, unf_nxt;
  logic              cfg_r, cfg_nxt;
  logic              err_r, err_nxt;
  logic [PC_W_P-1:0] pop_pc_r, pop_pc_nxt;
  logic              pop_valid_r, pop_valid_nxt;
  ras_ctx_type       rctx_r, rctx_nxt;
  logic              rvalid_r, rvalid_nxt;
  logic [31:0]       prdata_r, prdata_nxt;
  logic              pready_r, pready_nxt;
  logic              pslverr_r, pslverr_nxt;

  logic              mem_we;
  logic [PTR_W-1:0]  mem_waddr;
  logic [PC_W_P-1:0] mem_wdata;
  logic [PC_W_P-1:0] top_q;
  ras_ctx_type       shadow_q;
  logic              shadow_save;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic is_push, is_pop, is_sw_pop, apb_acc, apb_wr, apb_rd;
  assign is_push   = (req.op == RAS_CALL) || (req.op == RAS_RELATIVE_CALL_OP) ||
                     (req.op == RAS_INT_ACK) || (req.op == RAS_SW_PUSH);
  assign is_pop    = (req.op == RAS_RETURN) || (req.op == RAS_LIT_RETURN) ||
                     (req.op == RAS_INT_RETURN);
  assign is_sw_pop = (req.op == RAS_SW_POP);
  assign apb_acc   = psel && penable && !pready_r;
  assign apb_wr    = apb_acc && pwrite;
  assign apb_rd    = apb_acc && !pwrite;

  // Interrupts and fast calls overwrite the one shadow level
  assign shadow_save = (req.op == RAS_INT_ACK) || (req.op == RAS_CALL && req.fast);

  // ------------------------------------------------------------
  // Stack control
  // ------------------------------------------------------------
  always_comb begin
    ptr_nxt       = ptr_r;
    full_nxt      = full_r;
    unf_nxt       = unf_r;
    err_nxt       = 1'b0;
    pop_pc_nxt    = pop_pc_r;
    pop_valid_nxt = 1'b0;
    rctx_nxt      = rctx_r;
    rvalid_nxt    = 1'b0;
    mem_we        = 1'b0;
    mem_waddr     = ptr_r;
    mem_wdata     = req.pc;
    if (is_push) begin
      if (ptr_r == PTR_TOP) begin
        full_nxt = 1'b1;                                                   // dropped
      end else begin
        ptr_nxt   = ptr_r + PTR_W'(1);
        mem_we    = 1'b1;
        mem_waddr = ptr_nxt;
        if (ptr_nxt == PTR_TOP) begin
          full_nxt = 1'b1;
          if (cfg_r) begin
            mem_wdata = req.pc + PC_STEP;
            err_nxt   = 1'b1;
          end
        end
      end
    end else if (is_pop) begin
      pop_valid_nxt = 1'b1;
      if (ptr_r == PTR_EMPTY) begin
        pop_pc_nxt = '0;
        unf_nxt    = 1'b1;
        err_nxt    = cfg_r;
      end else begin
        pop_pc_nxt = top_q;                                                // read first
        ptr_nxt    = ptr_r - PTR_W'(1);
      end
      if (req.fast && (req.op == RAS_INT_RETURN || req.op == RAS_RETURN)) begin
        rctx_nxt   = shadow_q;
        rvalid_nxt = 1'b1;
      end
    end else if (is_sw_pop) begin
      if (ptr_r != PTR_EMPTY) begin
        ptr_nxt = ptr_r - PTR_W'(1);
      end else begin
        unf_nxt = 1'b1;
        err_nxt = cfg_r;
      end
    end
    // Software access; a hardware set in the same cycle wins over a clear
    if (apb_wr) begin
      unique case (paddr)
        ADDR_PTR_STATUS: begin
          ptr_nxt  = pwdata[PTR_W-1:0];
          full_nxt = full_nxt & (pwdata[FULL_BIT] | (full_nxt & !full_r));
          unf_nxt  = unf_nxt & (pwdata[UNF_BIT] | (unf_nxt & !unf_r));
        end
        ADDR_TOP_LOW: begin
          mem_we    = 1'b1;
          mem_waddr = ptr_r;
          mem_wdata = {top_q[PC_W_P-1:8], pwdata[7:0]};
        end
        ADDR_TOP_HIGH: begin
          mem_we    = 1'b1;
          mem_waddr = ptr_r;
          mem_wdata = {top_q[PC_W_P-1:16], pwdata[7:0], top_q[7:0]};
        end
        ADDR_TOP_UPPER: begin
          mem_we    = 1'b1;
          mem_waddr = ptr_r;
          mem_wdata = {pwdata[UPPER_W-1:0], top_q[15:0]};
        end
        default: begin
        end
      endcase
    end
    // Stack-error device reset forces the pointer to zero, flags kept
    if (err_r) begin
      ptr_nxt = PTR_EMPTY;
    end
  end

  always_comb begin
    cfg_nxt = cfg_r;
    if (apb_wr && paddr == ADDR_CONFIG) begin
      cfg_nxt = pwdata[0];
    end
  end

  // ------------------------------------------------------------
  // APB answer
  // ------------------------------------------------------------
  always_comb begin
    prdata_nxt  = '0;
    pready_nxt  = apb_acc;
    pslverr_nxt = 1'b0;
    if (apb_acc) begin
      case (paddr)
        ADDR_PTR_STATUS: prdata_nxt = {24'h00_0000, full_r, unf_r, 1'b0, ptr_r};
        ADDR_TOP_LOW:    prdata_nxt = {24'h00_0000, top_q[7:0]};
        ADDR_TOP_HIGH:   prdata_nxt = {24'h00_0000, top_q[15:8]};
        ADDR_TOP_UPPER:  prdata_nxt = {27'h000_0000, top_q[PC_W_P-1:16]};
        ADDR_CONFIG:     prdata_nxt = {31'h0000_0000, cfg_r};
        default:         pslverr_nxt = 1'b1;
      endcase
    end
    if (!apb_rd) begin
      prdata_nxt = '0;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Power-on reset is a reset too, so the pointer also clears on it
  always_ff @(posedge clk or posedge rst or posedge por) begin
    if (rst || por) begin
      ptr_r       <= PTR_EMPTY;
      err_r       <= 1'b0;
      pop_pc_r    <= '0;
      pop_valid_r <= 1'b0;
      rctx_r      <= '0;
      rvalid_r    <= 1'b0;
      prdata_r    <= '0;
      pready_r    <= 1'b0;
      pslverr_r   <= 1'b0;
    end else begin
      ptr_r       <= ptr_nxt;
      err_r       <= err_nxt;
      pop_pc_r    <= pop_pc_nxt;
      pop_valid_r <= pop_valid_nxt;
      rctx_r      <= rctx_nxt;
      rvalid_r    <= rvalid_nxt;
      prdata_r    <= prdata_nxt;
      pready_r    <= pready_nxt;
      pslverr_r   <= pslverr_nxt;
    end
  end

  // Flags and option survive device resets; only power-on resets them (flags to zero, option to CFG_RESET)
  always_ff @(posedge clk or posedge por) begin
    if (por) begin
      full_r <= 1'b0;
      unf_r  <= 1'b0;
      cfg_r  <= CFG_RESET;
    end else begin
      full_r <= full_nxt;
      unf_r  <= unf_nxt;
      cfg_r  <= cfg_nxt;
    end
  end

  // ------------------------------------------------------------
  // Storage and shadow
  // ------------------------------------------------------------
  ras_entry_mem #(
    .DEPTH_P (DEPTH_P),
    .WIDTH_P (PC_W_P),
    .AW_P    (PTR_W)
  ) u_mem (
    .clk   (clk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (ptr_r),
    .rdata (top_q)
  );

  ras_shadow u_shadow (
    .clk   (clk),
    .rst   (por),
    .save  (shadow_save),
    .live  (live_ctx),
    .saved (shadow_q)
  );

  assign pop_pc            = pop_pc_r;
  assign pop_valid         = pop_valid_r;
  assign restore_ctx       = rctx_r;
  assign restore_valid     = rvalid_r;
  assign stack_error_reset = err_r;
  assign prdata            = prdata_r;
  assign pready            = pready_r;
  assign pslverr           = pslverr_r;
endmodule

// ===== tb/ras_seq_model.sv
`timescale 1ns/1ns
module ras_seq_model
  import ras_pkg::*;
(
  // Clock
  input  wire logic     clk,
  // Request to the stack
  output ras_pkg::ras_req_type req,
  output ras_pkg::ras_ctx_type live_ctx
);
  initial begin
    req = '0;
    live_ctx = '0;
  end
  // One op a call; inputs scrambled once the op is taken
  task automatic issue(input ras_op_type op, input logic fast, input logic [PC_W-1:0] pc,
                       input ras_ctx_type c);
    @(posedge clk);
    req <= '{op, fast, pc};
    live_ctx <= c;
    @(posedge clk);
    req <= '{RAS_NONE, ~fast, ~pc};
    live_ctx <= ~c;
  endtask
endmodule

// ===== tb/ras_ctrl_chk.sv
`timescale 1ns/1ns
module ras_ctrl_chk
  import ras_pkg::*;
#(
  parameter int unsigned DEPTH_P = DEPTH,
  parameter int unsigned PC_W_P  = PC_W
) (
  // Clock and resets
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 por,
  // Sequencer side
  input wire ras_pkg::ras_req_type req,
  input wire ras_pkg::ras_ctx_type live_ctx,
  input wire logic [PC_W_P-1:0]    pop_pc,
  input wire logic                 pop_valid,
  input wire ras_pkg::ras_ctx_type restore_ctx,
  input wire logic                 restore_valid,
  input wire logic                 stack_error_reset,
  // APB
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr
);
  ras_ctx_type shd_r;
  ras_ctx_type shd_nxt;
  logic        hw_pop;
  logic        fast_ret;
  logic        save_ev;
  assign hw_pop = req.op inside {RAS_RETURN, RAS_LIT_RETURN, RAS_INT_RETURN};
  assign fast_ret = req.fast && (req.op inside {RAS_RETURN, RAS_INT_RETURN});
  assign save_ev = (req.op == RAS_INT_ACK) || (req.op == RAS_CALL && req.fast);
  always_comb begin
    shd_nxt = save_ev ? live_ctx : shd_r;
  end
  always_ff @(posedge clk or posedge por) begin
    if (por) shd_r <= '0;
    else shd_r <= shd_nxt;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst || por);
  ret_valid_a: assert property (hw_pop |=> pop_valid)
    else $error("pop answer missing");
  pop_cause_a: assert property (pop_valid |-> $past(hw_pop))
    else $error("pop answer without a pop");
  restore_val_a: assert property (fast_ret |=> restore_valid && restore_ctx == shd_r)
    else $error("fast return restored wrong context");
  restore_cause_a: assert property (restore_valid |-> $past(fast_ret))
    else $error("restore without fast return");
  err_cause_a: assert property (stack_error_reset |-> $past(req.op != RAS_NONE))
    else $error("error reset without an op");
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  stat_rsvd_a: assert property (pready && !pwrite && paddr == ADDR_PTR_STATUS
    |-> prdata[31:8] == 24'h00_0000 && !prdata[5])
    else $error("status reserved bits set");
  unmap_err_a: assert property (pready && (paddr > ADDR_CONFIG || paddr[1:0] != 2'b00)
    |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  cover property (pop_valid && pop_pc == '0);
  cover property (restore_valid);
  cover property (stack_error_reset);
endmodule
bind ras_ctrl ras_ctrl_chk #(.DEPTH_P(DEPTH_P), .PC_W_P(PC_W_P)) ras_ctrl_chk_i (
  .clk(clk), .rst(rst), .por(por), .req(req), .live_ctx(live_ctx), .pop_pc(pop_pc),
  .pop_valid(pop_valid), .restore_ctx(restore_ctx), .restore_valid(restore_valid),
  .stack_error_reset(stack_error_reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ===== tb/return_address_stack_ctrl_tb_top.sv
`timescale 1ns/1ns
module return_address_stack_ctrl_tb_top;
  import ras_pkg::*;
  logic clk = 1'b0, rst = 1'b1, por = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, seed;
  logic pop_valid, restore_valid, stack_error_reset, pready, pslverr, err_s;
  logic full = 1'b0, unf = 1'b0, en = 1'b1;
  logic [4:0] ptr = 5'h00;
  logic [PC_W-1:0] pop_pc, v;
  logic [PC_W-1:0] stk [0:31];
  ras_req_type req;
  ras_ctx_type live_ctx, restore_ctx, shd = '0;
  int failures = 0, checks_done = 0, cyc = 0, errs = 0, k;
  ras_op_type ops [6] = '{RAS_CALL, RAS_RELATIVE_CALL_OP, RAS_INT_ACK, RAS_RETURN, RAS_LIT_RETURN,
                         RAS_INT_RETURN};
  ras_ctrl ras_ctrl_i (.clk(clk), .rst(rst), .por(por), .req(req), .live_ctx(live_ctx),
    .pop_pc(pop_pc), .pop_valid(pop_valid), .restore_ctx(restore_ctx),
    .restore_valid(restore_valid), .stack_error_reset(stack_error_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  ras_seq_model ras_seq_model_i (.clk(clk), .req(req), .live_ctx(live_ctx));
  always #2 clk = ~clk;
  always @(negedge clk) if (stack_error_reset === 1'b1) errs++;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rd = prdata;
    err_s = pslverr;
    @(posedge clk);
    psel <= 1'b0; penable <= 1'b0; pwdata <= ~d;
  endtask
  function automatic logic [31:0] stat();
    return {24'h00_0000, full, unf, 1'b0, ptr};
  endfunction
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk("apb read", rd, e);
  endtask
  task automatic wr_stat(input logic [31:0] d);
    apb(1'b1, ADDR_PTR_STATUS, d);
    ptr = d[4:0]; full &= d[7]; unf &= d[6];
  endtask
  task automatic chk_top();
    logic [PC_W-1:0] t;
    t = (ptr == PTR_EMPTY) ? '0 : stk[ptr];
    rd_chk(ADDR_TOP_LOW, {24'h00_0000, t[7:0]});
    rd_chk(ADDR_TOP_HIGH, {24'h00_0000, t[15:8]});
    rd_chk(ADDR_TOP_UPPER, {27'h000_0000, t[20:16]});
  endtask
  task automatic do_op(input ras_op_type op, input logic fast);
    logic [PC_W-1:0] pc, ep;
    ras_ctx_type c, es;
    logic hw;
    int e0, ee;
    pc = PC_W'($urandom); c = ras_ctx_type'($urandom);
    e0 = errs; ee = 0; ep = '0; es = shd;
    hw = op inside {RAS_RETURN, RAS_LIT_RETURN, RAS_INT_RETURN};
    if (op inside {RAS_CALL, RAS_RELATIVE_CALL_OP, RAS_INT_ACK, RAS_SW_PUSH}) begin
      if (ptr != PTR_TOP) begin
        ptr++;
        stk[ptr] = pc;
        if (ptr == PTR_TOP && en) begin
          stk[ptr] = pc + PC_STEP; ptr = PTR_EMPTY; ee = 1; full = 1'b1;
        end
      end
      if (ptr == PTR_TOP) full = 1'b1;
    end else if (op == RAS_SW_POP) ptr--;
    else if (ptr == PTR_EMPTY) begin
      unf = 1'b1; ee = en;
    end else begin
      ep = stk[ptr]; ptr--;
    end
    if (op == RAS_INT_ACK || (op == RAS_CALL && fast)) shd = c;
    ras_seq_model_i.issue(op, fast, pc, c);
    @(negedge clk);
    chk("pop_valid", pop_valid, hw);
    if (hw) chk("pop_pc", pop_pc, ep);
    if (fast && op inside {RAS_RETURN, RAS_INT_RETURN}) chk("restore", restore_ctx, es);
    @(posedge clk);
    chk("error pulses", errs - e0, ee);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0; por <= 1'b0;
    seed = $urandom(32'h965070a0);
    rd_chk(ADDR_PTR_STATUS, stat());
    rd_chk(ADDR_CONFIG, 32'h0000_0001);
    for (int i = 0; i < 80; i++) begin
      k = $urandom_range(5);
      if (ptr < 5'd2) k = k % 3;
      if (ptr > 5'd28) k = 3 + k % 3;
      do_op(ops[k], 1'($urandom));
      if (i % 16 == 0) rd_chk(ADDR_PTR_STATUS, stat());
    end
    chk_top();
    while (ptr != PTR_EMPTY) do_op(RAS_LIT_RETURN, 1'b0);
    do_op(RAS_RETURN, 1'b0);
    wr_stat(32'h0000_0043);
    chk_top();
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    ptr = PTR_EMPTY;
    wr_stat(32'h0000_00c0);
    rd_chk(ADDR_PTR_STATUS, stat());
    apb(1'b1, ADDR_CONFIG, 32'h0000_0000);
    en = 1'b0;
    wr_stat(32'h0000_0000);
    repeat (32) do_op(RAS_CALL, 1'b0);
    rd_chk(ADDR_PTR_STATUS, stat());
    chk_top();
    wr_stat(32'h0000_0000);
    do_op(RAS_INT_RETURN, 1'b0);
    rd_chk(ADDR_CONFIG, 32'h0000_0000);
    apb(1'b1, ADDR_CONFIG, 32'h0000_0001);
    en = 1'b1;
    wr_stat(32'h0000_0000);
    repeat (31) do_op(RAS_RELATIVE_CALL_OP, 1'b0);
    rd_chk(ADDR_PTR_STATUS, stat());
    wr_stat(32'h0000_009f);
    chk_top();
    @(posedge clk) por <= 1'b1;
    @(posedge clk) por <= 1'b0;
    full = 1'b0; unf = 1'b0; ptr = PTR_EMPTY; shd = '0;
    rd_chk(ADDR_PTR_STATUS, stat());
    do_op(RAS_SW_PUSH, 1'b0);
    do_op(RAS_SW_PUSH, 1'b0);
    chk_top();
    do_op(RAS_SW_POP, 1'b0);
    chk_top();
    v = PC_W'($urandom);
    apb(1'b1, ADDR_TOP_LOW, {24'h00_0000, v[7:0]});
    apb(1'b1, ADDR_TOP_HIGH, {24'h00_0000, v[15:8]});
    apb(1'b1, ADDR_TOP_UPPER, {27'h000_0000, v[20:16]});
    stk[ptr] = v;
    do_op(RAS_RETURN, 1'b0);
    do_op(RAS_INT_ACK, 1'b0);
    do_op(RAS_INT_ACK, 1'b0);
    do_op(RAS_INT_RETURN, 1'b1);
    do_op(RAS_CALL, 1'b1);
    do_op(RAS_CALL, 1'b0);
    do_op(RAS_RETURN, 1'b1);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped error", err_s, 1'b1);
    tally_and_finish();
  end
endmodule
